/* hdl/ssram_pkg.sv */
package ssram_pkg;

  // Storage geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int MEM_DEPTH = 16384;

  // Asynchronous pin bundle: strobes, output enable, latch gate, data
  localparam int SYNC_W = 20;
  localparam int SYNC_LOW_N = 19;
  localparam int SYNC_HIGH_N = 18;
  localparam int SYNC_OE_N = 17;
  localparam int SYNC_DLE = 16;
  // Idle pin levels: strobes, output enable and latch gate high, data zero
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'hF0000;

  // Lane enable encodings
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] LANES_ALL = 2'h3;
  localparam logic [1:0] LANE_LOW = 2'h1;

  // Clock rate
  localparam int CLK_PERIOD_NS = 10;

  // Cycle type registered at the rising edge
  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0,
    CYC_READ = 2'h1,
    CYC_WRITE = 2'h2
  } cyc_t;

endpackage

/* hdl/sync_sram_16k_x16_regin.sv */
// Function
// - Hold 16384 words of 16 bits
// - Register address, selects, command each edge
// - Command low writes, high reads
// - Selected only when both selects active
// - Read drives word when output enable low
// - Output enable gates drivers, not cycle register
// - Low strobe writes low byte, high upper
// - Both strobes high cancels the write
// - Latch transparent while gate high, else holds
// - Data captured on falling latch gate
// - Strobes, enable, gate are unregistered inputs
// - Data bus released during power-up
// - Strobes ignored during read cycles
`timescale 1ns/1ps
module sync_sram_16k_x16_regin
  import ssram_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Registered control inputs
  input wire logic [ADDR_W-1:0] i_addr_bus,
  input wire logic i_chip_select_pos,
  input wire logic i_chip_select_neg,
  input wire logic i_sync_write_cmd_n,
  // Asynchronous control inputs
  input wire logic i_low_lane_strobe_n,
  input wire logic i_high_lane_strobe_n,
  input wire logic i_out_enable_n,
  input wire logic i_data_latch_gate,
  // Data bus, split into its three signals
  input wire logic [DATA_W-1:0] i_data_bus,
  output logic [DATA_W-1:0] o_data_bus,
  output logic o_data_bus_oe
);

  // Lanes to write for a cycle; none outside a write cycle
  function automatic logic [1:0] lane_enables(input cyc_t cyc, input logic [1:0] strobes_n);
    lane_enables = (cyc == CYC_WRITE) ? ~strobes_n : LANES_NONE;
  endfunction

  // Storage array, no reset
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // Stage registered at the command edge
  logic [ADDR_W-1:0] addr_q;
  cyc_t cyc_q;
  // Stage waiting while the cycle's pin sample crosses the synchroniser
  logic [ADDR_W-1:0] addr_wait_q;
  cyc_t cyc_wait_q;
  // Stage aligned with the synchronised pins
  logic [ADDR_W-1:0] addr_d1_q;
  cyc_t cyc_d1_q;
  // Two-flop synchroniser on the asynchronous pins
  logic [SYNC_W-1:0] pin_s1_q;
  logic [SYNC_W-1:0] pin_s2_q;
  // Input data latch content
  logic [DATA_W-1:0] latch_q;

  // Decoded views
  logic sel_raw;
  cyc_t cyc_raw;
  logic [1:0] strobes_n;
  logic oe_n;
  logic data_latch_gate;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] wdata;
  logic [1:0] lane_we;
  logic [DATA_W-1:0] cur_word;

  // Both selects must be active at the edge
  // select qualification
  assign sel_raw = i_chip_select_pos & ~i_chip_select_neg;
  assign cyc_raw = !sel_raw ? CYC_IDLE : (i_sync_write_cmd_n ? CYC_READ : CYC_WRITE);

  // Named fields of the synchronised bundle
  assign strobes_n = {pin_s2_q[SYNC_HIGH_N], pin_s2_q[SYNC_LOW_N]};
  assign oe_n = pin_s2_q[SYNC_OE_N];
  assign data_latch_gate = pin_s2_q[SYNC_DLE];
  assign din = pin_s2_q[DATA_W-1:0];

  // Gate high passes bus data, gate low uses captured word
  // transparent or latched write
  assign wdata = data_latch_gate ? din : latch_q;
  // strobes count only in write cycles
  assign lane_we = lane_enables(cyc_d1_q, strobes_n);
  // Word at the pending address
  assign cur_word = mem[addr_d1_q];

  // Command edge registers
  // capture at rising edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      addr_q <= '0;
      cyc_q <= CYC_IDLE;
    end else begin
      addr_q <= i_addr_bus;
      cyc_q <= cyc_raw;
    end
  end

  // Hold the cycle two more edges so it meets its own pin samples
  // Pins are taken at the edge after the command, then pass two flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      addr_wait_q <= '0;
      cyc_wait_q <= CYC_IDLE;
      addr_d1_q <= '0;
      cyc_d1_q <= CYC_IDLE;
    end else begin
      addr_wait_q <= addr_q;
      cyc_wait_q <= cyc_q;
      addr_d1_q <= addr_wait_q;
      cyc_d1_q <= cyc_wait_q;
    end
  end

  // Asynchronous pins pass two flops before use
  // unregistered pins synchronised
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pin_s1_q <= SYNC_RST;
      pin_s2_q <= SYNC_RST;
    end else begin
      pin_s1_q <= {i_low_lane_strobe_n, i_high_lane_strobe_n, i_out_enable_n, i_data_latch_gate, i_data_bus};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Input latch follows the bus while the gate is high
  // transparent or hold
  // last value kept at gate fall
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      latch_q <= '0;
    end else if (data_latch_gate) begin
      latch_q <= din;
    end
  end

  // Byte-lane write; a lane with its strobe high is untouched
  // byte lanes
  always_ff @(posedge i_clk_sys) begin
    for (int l = 0; l < LANES; l++) begin
      if (lane_we[l]) begin
        mem[addr_d1_q][l*LANE_W +: LANE_W] <= wdata[l*LANE_W +: LANE_W];
      end
    end
  end

  // Output data and driver enable
  // drive word on read
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_data_bus <= '0;
      o_data_bus_oe <= 1'b0;
    end else begin
      o_data_bus <= cur_word;
      o_data_bus_oe <= (cyc_d1_q == CYC_READ) & ~oe_n;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  sequence s_full_write;
    lane_we == LANES_ALL;
  endsequence

  sequence s_read_same;
    cyc_d1_q == CYC_READ && addr_d1_q == $past(addr_d1_q);
  endsequence

  a_cycle_capture: assert property (
    sel_raw && !i_sync_write_cmd_n |-> ##3 cyc_d1_q == CYC_WRITE)
    else $error("write command not carried to write stage");

  a_desel_released: assert property (
    !sel_raw |-> ##4 !o_data_bus_oe)
    else $error("deselected cycle drove the bus");

  a_write_released: assert property (
    cyc_d1_q == CYC_WRITE |=> !o_data_bus_oe)
    else $error("write cycle drove the bus");

  a_read_drives: assert property (
    cyc_d1_q == CYC_READ && !oe_n |=> o_data_bus_oe && o_data_bus == $past(cur_word))
    else $error("read did not drive stored word");

  a_oe_gates: assert property (
    cyc_d1_q == CYC_READ && oe_n |=> !o_data_bus_oe)
    else $error("bus driven with output enable high");

  a_full_readback: assert property (
    s_full_write ##1 s_read_same |=> o_data_bus == $past(wdata, 2))
    else $error("read back differs from written word");

  a_upper_kept: assert property (
    lane_we == LANE_LOW |=> mem[$past(addr_d1_q)][DATA_W-1:LANE_W] == $past(cur_word[DATA_W-1:LANE_W]))
    else $error("upper byte changed on low-lane write");

  a_abort_nowrite: assert property (
    cyc_d1_q == CYC_WRITE && strobes_n == LANES_ALL |=> mem[$past(addr_d1_q)] == $past(cur_word))
    else $error("aborted write changed memory");

  a_read_nowrite: assert property (
    cyc_d1_q == CYC_READ |=> mem[$past(addr_d1_q)] == $past(cur_word))
    else $error("read cycle changed memory");

  a_latch_hold: assert property (
    !data_latch_gate |=> $stable(latch_q))
    else $error("latch changed while gate low");

  a_latch_fall: assert property (
    $fell(data_latch_gate) |-> latch_q == $past(din))
    else $error("latch missed value at gate fall");

  a_reset_released: assert property (
    @(posedge i_clk_sys) disable iff (1'b0) !i_nrst |=> !o_data_bus_oe)
    else $error("bus driven after reset");

endmodule

/* sim/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model
  import ssram_pkg::*;
(
  // Clock and device answer
  input wire logic i_clk,
  input wire logic [DATA_W-1:0] i_q,
  input wire logic i_q_oe,
  // Pins toward the memory
  output logic [ADDR_W-1:0] o_addr_bus,
  output logic [2:0] o_ctl,
  output logic [3:0] o_pins,
  output logic [DATA_W-1:0] o_data_bus
);
  // Idle: deselected, strobes, enable and gate high
  initial begin
    o_addr_bus = 14'h0000;
    o_ctl = 3'h3;
    o_pins = 4'hF;
    o_data_bus = 16'h0000;
  end
  // One cycle: command, pin phase, release, then take the answer
  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [2:0] ctl, input logic [2:0] pin, input logic gate,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic qoe);
    @(negedge i_clk);
    o_addr_bus = a;
    o_ctl = ctl;
    o_pins = {pin, 1'b1};
    o_data_bus = d;
    @(negedge i_clk);
    o_ctl = 3'h3;
    // gate kept high or dropped mid-cycle
    o_pins[0] = gate;
    o_data_bus = gate ? d : ~d;
    @(negedge i_clk);
    // Released bus shows the inverse, not the last value
    o_pins = 4'hF;
    o_data_bus = ~o_data_bus;
    repeat (2) @(negedge i_clk);
    q = i_q;
    qoe = i_q_oe;
  endtask
  // Write then read of the same word on consecutive edges, gate high
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
    output logic qoe);
    @(negedge i_clk);
    // write command, read command one edge later
    o_addr_bus = a;
    o_ctl = 3'h4;
    o_pins = 4'h1;
    o_data_bus = d;
    @(negedge i_clk);
    o_ctl = 3'h5;
    @(negedge i_clk);
    // Read cycle pins: output enable low, strobes left low
    o_ctl = 3'h3;
    o_data_bus = ~d;
    @(negedge i_clk);
    o_pins = 4'hF;
    repeat (2) @(negedge i_clk);
    q = i_q;
    qoe = i_q_oe;
  endtask
endmodule

/* sim/sync_sram_16k_x16_regin_tb_top.sv */
`timescale 1ns/1ps
module sync_sram_16k_x16_regin_tb_top
  import ssram_pkg::*;
;
  // Clock, reset and pins
  logic clk, nrst;
  logic [ADDR_W-1:0] addr_bus;
  logic [2:0] ctl;
  logic [3:0] pins;
  logic [DATA_W-1:0] data_in, data_out;
  logic data_oe;
  int n_fail = 0;
  int n_checks = 0;
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  host_bus_model host (.i_clk(clk), .i_q(data_out), .i_q_oe(data_oe), .o_addr_bus(addr_bus), .o_ctl(ctl),
    .o_pins(pins), .o_data_bus(data_in));
  sync_sram_16k_x16_regin uut (.i_clk_sys(clk), .i_nrst(nrst), .i_addr_bus(addr_bus), .i_chip_select_pos(ctl[2]),
    .i_chip_select_neg(ctl[1]), .i_sync_write_cmd_n(ctl[0]), .i_high_lane_strobe_n(pins[3]),
    .i_low_lane_strobe_n(pins[2]), .i_out_enable_n(pins[1]), .i_data_latch_gate(pins[0]),
    .i_data_bus(data_in), .o_data_bus(data_out), .o_data_bus_oe(data_oe));
  // Compare and count
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write cycle; the bus must stay released
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [2:0] c, input logic [1:0] we_n, input logic g,
    input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic qoe;
    host.cyc(a, c, {we_n, 1'b0}, g, d, q, qoe);
    chk({15'h0000, qoe}, 16'h0000);
  endtask
  // Read cycle with both strobes low
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [2:0] c, input logic oe_n, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] q;
    logic qoe;
    host.cyc(a, c, {2'h0, oe_n}, 1'b1, 16'h0000, q, qoe);
    chk({15'h0000, qoe}, {15'h0000, c == 3'h5 && !oe_n});
    if (qoe === 1'b1) chk(q, e);
  endtask
  // Full words at both ends of the array
  task automatic t_word();
    wr(14'h0000, 3'h4, 2'h0, 1'b1, 16'hA5C3);
    wr(14'h3FFF, 3'h4, 2'h0, 1'b1, 16'h5A3C);
    rd(14'h0000, 3'h5, 1'b0, 16'hA5C3);
    rd(14'h3FFF, 3'h5, 1'b0, 16'h5A3C);
  endtask
  // Each lane alone
  task automatic t_lanes();
    wr(14'h0001, 3'h4, 2'h0, 1'b1, 16'h1111);
    wr(14'h0001, 3'h4, 2'h2, 1'b1, 16'h22EE);
    rd(14'h0001, 3'h5, 1'b0, 16'h11EE);
    wr(14'h0001, 3'h4, 2'h1, 1'b1, 16'h3344);
    rd(14'h0001, 3'h5, 1'b0, 16'h33EE);
  endtask
  // Latched data, abort, deselects, disabled output
  task automatic t_misc();
    wr(14'h0002, 3'h4, 2'h0, 1'b0, 16'h6789);
    rd(14'h0002, 3'h5, 1'b0, 16'h6789);
    wr(14'h0001, 3'h4, 2'h3, 1'b1, 16'hFFFF);
    wr(14'h0001, 3'h0, 2'h0, 1'b1, 16'h0000);
    wr(14'h0001, 3'h6, 2'h0, 1'b1, 16'h0000);
    rd(14'h0001, 3'h1, 1'b0, 16'h0000);
    rd(14'h0001, 3'h7, 1'b0, 16'h0000);
    rd(14'h0001, 3'h5, 1'b1, 16'h0000);
    rd(14'h0001, 3'h5, 1'b0, 16'h33EE);
  endtask
  // Write and read of one word on consecutive edges
  task automatic t_back();
    logic [DATA_W-1:0] q;
    logic qoe;
    host.wr_rd(14'h0003, 16'hC33C, q, qoe);
    chk({15'h0000, qoe}, 16'h0001);
    chk(q, 16'hC33C);
  endtask
  // Counts and verdict
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({15'h0000, data_oe}, 16'h0000);
    t_word();
    t_lanes();
    t_misc();
    t_back();
    results();
  end
endmodule
